// ### rtl/pci_defs.svh
// register offsets, field positions and reset values of the pin change block
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH
`define PCI_ADDR_W 4
`define PCI_OFF_RISE 4'h0
`define PCI_OFF_FALL 4'h1
`define PCI_OFF_FLAGS 4'h2
`define PCI_OFF_CTRL 4'h3
`define PCI_OFF_IRQ_STAT 4'h4
`define PCI_OFF_IRQ_CLR 4'h5
`define PCI_OFF_IRQ_EN 4'h6
`define PCI_CTRL_MASTER_BIT 0
`define PCI_CTRL_SUMMARY_BIT 1
`define PCI_CTRL_SLEEP_BIT 2
`define PCI_IRQ_EDGE_BIT 0
`define PCI_IRQ_WAKE_BIT 1
`define PCI_RST_RISE 8'h00
`define PCI_RST_FALL 8'h00
`define PCI_RST_FLAGS 8'h00
`define PCI_RST_CTRL 8'h00
`define PCI_RST_IRQ 8'h00
`endif

// ### rtl/pci_pkg.sv
// types shared by the pin change block
package pci_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pci_bus_req_t;

    typedef enum logic [1:0] {
        PCI_RUN,
        PCI_SLEEP,
        PCI_WAKE
    } pci_pwr_t;
endpackage

// ### rtl/pci_pin_change.sv
// pin change interrupt block: edge detect, flags, wake and register slave
// What this block does
// - with master enable set, an enabled pin edge wakes the device from sleep.
// - flags are updated before the core runs its first instruction after wake.
// - each rising enable bit, reset zero, enables rising detection and sets flags.
// - each falling enable bit, reset zero, enables falling detection and sets flags.
// - a cleared enable bit reports no edges of that direction on that pin.
// - flag sets on rising edge with rising enable, or falling edge with falling enable.
// - flags reset to zero; written zero clears; hardware leaves them clear after.
// - with master enable clear, flags still set and core_int_req stays low; the edge status bit can still raise irq.
// - the summary flag is the logical or of all per-pin flags.
// - an edge during a flag write leaves that pin's flag set.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`include "pci_defs.svh"
module pci_pin_change #(
    parameter int PINS = 8
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [PINS-1:0] port_pin_x,
    input wire logic [`PCI_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic core_int_req,
    output logic core_wake,
    output logic change_summary_flag,
    output logic irq
);
    // flag and register paths are one byte wide; other pin counts are refused
    if (PINS != 8)
    begin
        $error("pci_pin_change supports exactly 8 pins");
    end

    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_n = rst_sync_r;

    pci_pkg::pci_bus_req_t req;
    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    // three stage synchroniser; a change counts when stages two and three agree
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] sync3_r;
    logic [7:0] level_r;
    logic level_ok_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            sync3_r <= 8'h00;
        end
        else
        begin
            sync1_r <= port_pin_x;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    wire [7:0] stable_mask = ~(sync2_r ^ sync3_r);
    wire [7:0] level_nxt = (sync3_r & stable_mask) | (level_r & ~stable_mask);

    logic [1:0] fill_r;
    // stage three holds reset zeros until the third edge; seeding earlier would
    // turn a pin that is high at reset into a false rising edge
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fill_r <= 2'h0;
            level_r <= 8'h00;
            level_ok_r <= 1'b0;
        end
        else
        begin
            if (fill_r != 2'h3)
                fill_r <= 2'(fill_r + 2'h1);
            level_r <= level_ok_r ? level_nxt : sync3_r;
            level_ok_r <= fill_r == 2'h3;
        end
    end

    logic [7:0] rise_edge_enable;
    logic [7:0] fall_edge_enable;
    logic [7:0] pin_change_flags;
    logic change_master_enable;
    logic sleep_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    pci_pkg::pci_pwr_t pwr_r;
    pci_pkg::pci_pwr_t pwr_nxt;

    wire [7:0] rise_seen = level_nxt & ~level_r & {8{level_ok_r}};
    wire [7:0] fall_seen = ~level_nxt & level_r & {8{level_ok_r}};
    wire [7:0] edge_hit = (rise_seen & rise_edge_enable)
        | (fall_seen & fall_edge_enable);

    wire wr_rise = req.wr && req.addr == `PCI_OFF_RISE;
    wire wr_fall = req.wr && req.addr == `PCI_OFF_FALL;
    wire wr_flags = req.wr && req.addr == `PCI_OFF_FLAGS;
    wire wr_ctrl = req.wr && req.addr == `PCI_OFF_CTRL;
    wire wr_iclr = req.wr && req.addr == `PCI_OFF_IRQ_CLR;
    wire wr_ien = req.wr && req.addr == `PCI_OFF_IRQ_EN;

    // writes only clear; a set in the same cycle wins so no edge is lost
    wire [7:0] flags_keep = wr_flags ? (pin_change_flags & req.wdata) : pin_change_flags;
    wire [7:0] flags_nxt = flags_keep | edge_hit;
    wire summary_nxt = |flags_nxt;
    wire int_nxt = summary_nxt && change_master_enable;
    wire wake_event = sleep_r && int_nxt;
    wire [1:0] irq_ev = {wake_event, |edge_hit};
    wire [1:0] irq_stat_nxt = (irq_stat_r & ~(wr_iclr ? req.wdata[1:0] : 2'h0)) | irq_ev;

    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            pci_pkg::PCI_RUN:
                if (wr_ctrl && req.wdata[`PCI_CTRL_SLEEP_BIT])
                    pwr_nxt = pci_pkg::PCI_SLEEP;
            pci_pkg::PCI_SLEEP:
                if (int_nxt)
                    pwr_nxt = pci_pkg::PCI_WAKE;
            default:
                pwr_nxt = pci_pkg::PCI_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_edge_enable <= `PCI_RST_RISE;
            fall_edge_enable <= `PCI_RST_FALL;
            pin_change_flags <= `PCI_RST_FLAGS;
            change_master_enable <= 1'b0;
            irq_stat_r <= 2'h0;
            irq_en_r <= 2'h0;
            pwr_r <= pci_pkg::PCI_RUN;
        end
        else
        begin
            if (wr_rise)
                rise_edge_enable <= req.wdata;
            if (wr_fall)
                fall_edge_enable <= req.wdata;
            pin_change_flags <= flags_nxt;
            if (wr_ctrl)
                change_master_enable <= req.wdata[`PCI_CTRL_MASTER_BIT];
            irq_stat_r <= irq_stat_nxt;
            if (wr_ien)
                irq_en_r <= req.wdata[1:0];
            pwr_r <= pwr_nxt;
        end
    end
    assign sleep_r = pwr_r == pci_pkg::PCI_SLEEP;

    // outputs come straight from flops; wake rises with the flags already stored
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            change_summary_flag <= 1'b0;
            core_int_req <= 1'b0;
            core_wake <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            change_summary_flag <= summary_nxt;
            core_int_req <= int_nxt;
            core_wake <= pwr_r == pci_pkg::PCI_SLEEP && int_nxt;
            irq <= |(irq_stat_nxt & (wr_ien ? req.wdata[1:0] : irq_en_r));
        end
    end

    wire [7:0] ctrl_rd = {5'h00, sleep_r, |pin_change_flags, change_master_enable};
    wire [7:0] rd_mux =
        (req.addr == `PCI_OFF_RISE) ? rise_edge_enable :
        (req.addr == `PCI_OFF_FALL) ? fall_edge_enable :
        (req.addr == `PCI_OFF_FLAGS) ? pin_change_flags :
        (req.addr == `PCI_OFF_CTRL) ? ctrl_rd :
        (req.addr == `PCI_OFF_IRQ_STAT) ? {6'h00, irq_stat_r} :
        (req.addr == `PCI_OFF_IRQ_EN) ? {6'h00, irq_en_r} : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rdata <= 8'h00;
        else if (req.rd)
            bus_rdata <= rd_mux;
        else
            bus_rdata <= 8'h00;
    end

    property p_edge_sets_flag;
        @(posedge core_clk) disable iff (!rst_n)
        (edge_hit[0]) |=> pin_change_flags[0];
    endproperty
    a_edge_sets_flag: assert property (p_edge_sets_flag)
        else $error("enabled edge did not set flag");

    property p_rise_disabled;
        @(posedge core_clk) disable iff (!rst_n)
        (!rise_edge_enable[1] && !fall_edge_enable[1] && !pin_change_flags[1]
            && !(wr_flags && 1'b0)) |=> !pin_change_flags[1];
    endproperty
    a_rise_disabled: assert property (p_rise_disabled)
        else $error("disabled pin reported a change");

    property p_write_race;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_flags && edge_hit[2]) |=> pin_change_flags[2];
    endproperty
    a_write_race: assert property (p_write_race)
        else $error("edge lost during flag write");

    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_flags && !req.wdata[3] && !edge_hit[3]) |=> !pin_change_flags[3];
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not cleared by zero write");

    property p_summary;
        @(posedge core_clk) disable iff (!rst_n)
        change_summary_flag == (|pin_change_flags);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary flag differs from or of flags");

    property p_no_int_masked;
        @(posedge core_clk) disable iff (!rst_n)
        (!change_master_enable) |=> !core_int_req;
    endproperty
    a_no_int_masked: assert property (p_no_int_masked)
        else $error("interrupt raised with master enable clear");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_n)
        (sleep_r && change_master_enable && edge_hit != 8'h00) |=> core_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on enabled edge in sleep");

    property p_wake_flags;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(core_wake) |-> pin_change_flags != 8'h00;
    endproperty
    a_wake_flags: assert property (p_wake_flags)
        else $error("woke before flags were updated");

    property p_rise_seen;
        @(posedge core_clk) disable iff (!rst_n)
        (rise_edge_enable[4] && rise_seen[4]) |=> pin_change_flags[4];
    endproperty
    a_rise_seen: assert property (p_rise_seen)
        else $error("rising edge not flagged");

    property p_fall_seen;
        @(posedge core_clk) disable iff (!rst_n)
        (fall_edge_enable[5] && fall_seen[5]) |=> pin_change_flags[5];
    endproperty
    a_fall_seen: assert property (p_fall_seen)
        else $error("falling edge not flagged");

    property p_glitch_filtered;
        @(posedge core_clk) disable iff (!rst_n)
        (sync2_r[7] != sync3_r[7]) |-> !rise_seen[7] && !fall_seen[7];
    endproperty
    a_glitch_filtered: assert property (p_glitch_filtered)
        else $error("edge counted before synchroniser stages agreed");

    property p_masked_flags;
        @(posedge core_clk) disable iff (!rst_n)
        (!change_master_enable && edge_hit != 8'h00) |=> pin_change_flags != 8'h00;
    endproperty
    a_masked_flags: assert property (p_masked_flags)
        else $error("flags not set while master enable clear");

    c_edge: cover property (@(posedge core_clk) disable iff (!rst_n) edge_hit != 8'h00);
    c_race: cover property (@(posedge core_clk) disable iff (!rst_n) wr_flags && |edge_hit);
    c_wake: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(core_wake));
    c_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));
endmodule

// ### testbench/pci_pin_src.sv
// far-side model: off-chip sources driving the port pins
`timescale 1ns/10ps
module pci_pin_src (
    input wire logic core_clk,
    input wire logic [7:0] level,
    input wire logic [3:0] lag,
    output logic [7:0] port_pin_x
);
    initial port_pin_x = 8'h00;
    // pins are asynchronous, so the change lands mid-cycle after a chosen lag
    always @(level)
    begin
        repeat (lag) @(posedge core_clk);
        #7 port_pin_x = level;
    end
endmodule

// ### testbench/pci_pin_change_bench.sv
// self-checking bench for the pin change block
`timescale 1ns/10ps
`include "pci_defs.svh"
module pci_pin_change_bench;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] level = 8'h00;
    logic [3:0] lag = 4'h0;
    logic [7:0] pins;
    logic [3:0] bus_addr = 4'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic core_int_req;
    logic core_wake;
    logic change_summary_flag;
    logic irq;
    logic [7:0] v;
    int fail_count = 0;
    int compares = 0;

    initial forever #10 core_clk = ~core_clk;

    pci_pin_src SRC (.core_clk(core_clk), .level(level), .lag(lag), .port_pin_x(pins));
    pci_pin_change DUT (.core_clk(core_clk), .arst_n(arst_n), .port_pin_x(pins),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .core_int_req(core_int_req), .core_wake(core_wake),
        .change_summary_flag(change_summary_flag), .irq(irq));

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // move the pins, then leave room for sync, detect and the flag pipeline
    task automatic drive(input logic [7:0] l, input logic [3:0] g);
        lag = g;
        level = l;
        repeat (int'(g) + 9) @(posedge core_clk);
    endtask

    task automatic wrap_up;
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_rd(`PCI_OFF_RISE, `PCI_RST_RISE);
        chk_rd(`PCI_OFF_FALL, `PCI_RST_FALL);
        chk_rd(`PCI_OFF_FLAGS, `PCI_RST_FLAGS);
        chk_rd(4'h9, 8'h00);
        wr(`PCI_OFF_RISE, 8'h0f);
        wr(`PCI_OFF_FALL, 8'hf0);
        chk_rd(`PCI_OFF_RISE, 8'h0f);
        chk_rd(`PCI_OFF_FALL, 8'hf0);
        // all pins rise: only the low nibble may report, master still off
        drive(8'hff, 4'h0);
        chk_rd(`PCI_OFF_FLAGS, 8'h0f);
        chk({7'h00, change_summary_flag}, 8'h01);
        chk({7'h00, core_int_req}, 8'h00);
        drive(8'h00, 4'h3);
        chk_rd(`PCI_OFF_FLAGS, 8'hff);
        // a one in the write keeps the flag, a zero clears it
        wr(`PCI_OFF_FLAGS, 8'h0f);
        chk_rd(`PCI_OFF_FLAGS, 8'h0f);
        rd(`PCI_OFF_FLAGS, v);
        wr(`PCI_OFF_FLAGS, v ^ 8'hff);
        repeat (3) @(posedge core_clk);
        chk_rd(`PCI_OFF_FLAGS, 8'h00);
        chk({7'h00, change_summary_flag}, 8'h00);
        // interrupt path with master on: raise, mask, clear
        wr(`PCI_OFF_CTRL, 8'h01);
        wr(`PCI_OFF_IRQ_EN, 8'h01);
        drive(8'hff, 4'h1);
        chk({6'h00, irq, core_int_req}, 8'h03);
        chk_rd(`PCI_OFF_CTRL, 8'h03);
        rd(`PCI_OFF_IRQ_STAT, v);
        chk(v & 8'h01, 8'h01);
        wr(`PCI_OFF_IRQ_EN, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irq}, 8'h00);
        wr(`PCI_OFF_IRQ_CLR, 8'h03);
        wr(`PCI_OFF_IRQ_EN, 8'h01);
        wr(`PCI_OFF_FLAGS, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({6'h00, irq, core_int_req}, 8'h00);
        // sleep, then a falling edge on the high nibble must wake the core
        wr(`PCI_OFF_CTRL, 8'h05);
        chk_rd(`PCI_OFF_CTRL, 8'h05);
        lag = 4'h5;
        level = 8'h00;
        v = 8'h00;
        for (int i = 0; i < 40 && v == 8'h00; i++)
        begin
            @(posedge core_clk);
            #1;
            if (core_wake === 1'b1)
                v = {7'h00, change_summary_flag};
        end
        chk(v, 8'h01);
        chk_rd(`PCI_OFF_FLAGS, 8'hf0);
        chk_rd(`PCI_OFF_CTRL, 8'h03);
        rd(`PCI_OFF_IRQ_STAT, v);
        chk(v & 8'h02, 8'h02);
        // pin 2 rises in the very cycle software writes zero: the set must win
        lag = 4'h0;
        level = 8'h04;
        repeat (2) @(posedge core_clk);
        wr(`PCI_OFF_FLAGS, 8'h00);
        chk_rd(`PCI_OFF_FLAGS, 8'h04);
        // reset again with pins high: seeding the level must not count as an edge
        drive(8'hff, 4'h0);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        wr(`PCI_OFF_RISE, 8'hff);
        repeat (8) @(posedge core_clk);
        chk_rd(`PCI_OFF_FLAGS, 8'h00);
        chk({5'h00, core_wake, irq, core_int_req}, 8'h00);
        drive(8'h00, 4'h0);
        drive(8'h01, 4'h2);
        chk_rd(`PCI_OFF_FLAGS, 8'h01);
        wrap_up();
    end
endmodule
